/* include/jba_if.sv */
// scan-chain pins between the debug master and the device
`timescale 1ns/10ps
interface jba_if;
	logic tck;
	logic tms;
	logic tdi;
	logic tdo;
	logic tdo_oe;
	modport dev  (input tck, input tms, input tdi, output tdo, output tdo_oe);
	modport host (output tck, output tms, output tdi, input tdo, input tdo_oe);
endinterface : jba_if

/* include/jba_pkg.sv */
// shared constants and types of the scan-chain bus access link
package jba_pkg;
	localparam int         DR_W       = 35;
	localparam int         IR_W       = 5;
	localparam int         BA_W       = 36;
	localparam logic [4:0] IR_WORD    = 5'h11;
	localparam logic [4:0] IR_BLOCK   = 5'h12;
	localparam logic [4:0] IR_CANCEL  = 5'h13;
	localparam logic [4:0] IR_SYNC    = 5'h17;
	localparam logic [4:0] IR_DRST    = 5'h0c;
	localparam logic [4:0] IR_BYPASS  = 5'h1f;
	localparam logic [5:0] LEN_WORD   = 6'h23;
	localparam logic [5:0] LEN_BLOCK  = 6'h22;
	localparam logic [5:0] LEN_SYNC   = 6'h10;
	localparam logic [5:0] LEN_DRST   = 6'h05;
	localparam logic [5:0] LEN_ONE    = 6'h01;
	localparam logic [1:0] CAP_LOW    = 2'h1;
	localparam logic [4:0] CAP_PLAIN  = 5'h01;
	localparam logic [1:0] SIZE_WORD  = 2'h2;
	localparam int         DRST_CPU   = 0;
	localparam int         DRST_SYS   = 3;
	localparam int         DRST_DBG   = 4;
	localparam logic [7:0] REG_CMD    = 8'h00;
	localparam logic [7:0] REG_TDI_LO = 8'h04;
	localparam logic [7:0] REG_TDI_HI = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0c;
	localparam logic [7:0] REG_TDO_LO = 8'h10;
	localparam logic [7:0] REG_TDO_HI = 8'h14;
	localparam logic [1:0] OP_IR      = 2'h0;
	localparam logic [1:0] OP_DR      = 2'h1;
	localparam logic [1:0] OP_IDLE    = 2'h2;
	localparam logic [1:0] OP_RESET   = 2'h3;
	localparam logic [7:0] PRE_IR     = 8'h03;
	localparam logic [7:0] PRE_DR     = 8'h01;
	localparam logic [7:0] PRE_RESET  = 8'h1f;
	localparam logic [1:0] POST_UPD   = 2'h1;
	localparam logic [1:0] RESP_OKAY  = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int         TCK_HALF   = 8;
	typedef enum logic [3:0] {
		st_reset, st_idle, st_sel_dr, st_cap_dr, st_sh_dr, st_ex1_dr,
		st_pau_dr, st_ex2_dr, st_upd_dr, st_sel_ir, st_cap_ir, st_sh_ir,
		st_ex1_ir, st_pau_ir, st_ex2_ir, st_upd_ir
	} jba_tap_t;
endpackage : jba_pkg

/* rtl/jba_dev.sv */
// device end: test access port with bus access, sync and domain resets
// Contract
// - word access: 34 address bits, word size
// - address phase first, toggle on idle scan
// - master scans direction bit plus address
// - master shifts full address and write data
// - reads may stop shifting early
// - capture status pattern, error/busy before data; here they are shifted out after the read data
// - block access repeats, address advances by size
// - master sets start address beforehand
// - block code 0x12, 34-bit register
// - block scans chain through update
// - block word overhead four clocks
// - cancel aborts access, reports timeout
// - cancel register one bit, reads zero
// - sync loads 16-bit down-counter, busy
// - master polls busy after sync load
// - domain reset bits hold domains
// - master idles ten clocks after reset
// - master shifts all reset bits
// - five bits: cpu, buses, debug
//
// Decided for this implementation: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/10ps
module jba_dev
	import jba_pkg::*;
#(
	parameter logic PROT = 1'b0
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	jba_if.dev                     jt,
	output logic                   sb_req,
	output logic                   sb_we,
	output logic [BA_W-1:0]        sb_addr,
	output logic [1:0]             sb_size,
	output logic [31:0]            sb_wdata,
	output logic                   sb_cancel,
	input  wire logic              sb_ack,
	input  wire logic              sb_err,
	input  wire logic [31:0]       sb_rdata,
	output logic                   rst_cpu,
	output logic                   rst_sysbus,
	output logic                   rst_debug
);
	logic [2:0]      tck_q;
	logic [1:0]      tms_q;
	logic [1:0]      tdi_q;
	logic            tms_s;
	logic            tdi_s;
	logic            tck_rise;
	logic            tck_fall;
	jba_tap_t        tap;
	jba_tap_t        next_tap;
	logic [IR_W-1:0] ir;
	logic [IR_W-1:0] ir_sh;
	logic [IR_W-1:0] cap_ir;
	logic [DR_W-1:0] dr;
	logic [DR_W-1:0] next_dr;
	logic [DR_W-1:0] cap_dr;
	logic [5:0]      dr_len;
	logic            addr_phase;
	logic            err;
	logic            busy;
	logic [31:0]     rdata;
	logic [15:0]     sync_cnt;
	logic [4:0]      dom_rst;
	logic            upd_any;
	logic            upd_dr;
	logic            upd_ir;
	logic            word_upd;
	logic            blk_upd;
	logic            pref;
	logic            go;
	logic            go_we;
	logic [BA_W-1:0] inc;

	// tck is only sampled; two flops before any logic sees the pins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tck_q <= 3'h0;
			tms_q <= 2'h3;
			tdi_q <= 2'h0;
		end else begin
			tck_q <= {tck_q[1:0], jt.tck};
			tms_q <= {tms_q[0], jt.tms};
			tdi_q <= {tdi_q[0], jt.tdi};
		end
	end

	assign tms_s    = tms_q[1];
	assign tdi_s    = tdi_q[1];
	assign tck_rise = tck_q[1] & ~tck_q[2];
	assign tck_fall = ~tck_q[1] & tck_q[2];

	always_comb begin
		unique case (tap)
		st_reset:  next_tap = tms_s ? st_reset : st_idle;
		st_idle:   next_tap = tms_s ? st_sel_dr : st_idle;
		st_sel_dr: next_tap = tms_s ? st_sel_ir : st_cap_dr;
		st_cap_dr: next_tap = tms_s ? st_ex1_dr : st_sh_dr;
		st_sh_dr:  next_tap = tms_s ? st_ex1_dr : st_sh_dr;
		st_ex1_dr: next_tap = tms_s ? st_upd_dr : st_pau_dr;
		st_pau_dr: next_tap = tms_s ? st_ex2_dr : st_pau_dr;
		st_ex2_dr: next_tap = tms_s ? st_upd_dr : st_sh_dr;
		st_upd_dr: next_tap = tms_s ? st_sel_dr : st_idle;
		st_sel_ir: next_tap = tms_s ? st_reset : st_cap_ir;
		st_cap_ir: next_tap = tms_s ? st_ex1_ir : st_sh_ir;
		st_sh_ir:  next_tap = tms_s ? st_ex1_ir : st_sh_ir;
		st_ex1_ir: next_tap = tms_s ? st_upd_ir : st_pau_ir;
		st_pau_ir: next_tap = tms_s ? st_ex2_ir : st_pau_ir;
		st_ex2_ir: next_tap = tms_s ? st_upd_ir : st_sh_ir;
		st_upd_ir: next_tap = tms_s ? st_sel_dr : st_idle;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			tap <= st_reset;
		else if (tck_rise)
			tap <= next_tap;
	end

	assign busy = sb_req | (sync_cnt != 16'h0);

	always_comb begin
		unique case (ir)
		IR_WORD, IR_BLOCK, IR_CANCEL, IR_SYNC:
			cap_ir = {PROT, err, busy, CAP_LOW};
		default:
			cap_ir = CAP_PLAIN;
		endcase
	end

	always_comb begin
		unique case (ir)
		IR_WORD:   dr_len = LEN_WORD;
		IR_BLOCK:  dr_len = LEN_BLOCK;
		IR_SYNC:   dr_len = LEN_SYNC;
		IR_DRST:   dr_len = LEN_DRST;
		default:   dr_len = LEN_ONE;
		endcase
	end

	// error and busy are shifted out after the read data
	always_comb begin
		unique case (ir)
		IR_WORD:
			cap_dr = addr_phase ? {33'h0, err, busy}
				: {1'b0, err, busy, rdata};
		IR_BLOCK:  cap_dr = {1'b0, err, busy, rdata};
		IR_SYNC:   cap_dr = {33'h0, err, busy};
		IR_DRST:   cap_dr = {30'h0, dom_rst};
		default:   cap_dr = '0;
		endcase
	end

	// bits enter at the top of the selected length, so data lands at bit 0
	always_comb begin
		next_dr = {1'b0, dr[DR_W-1:1]};
		next_dr[dr_len - 6'h01] = tdi_s;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dr    <= '0;
			ir_sh <= '0;
		end else if (tck_rise) begin
			if (tap == st_cap_dr)
				dr <= cap_dr;
			else if (tap == st_sh_dr)
				dr <= next_dr;
			if (tap == st_cap_ir)
				ir_sh <= cap_ir;
			else if (tap == st_sh_ir)
				ir_sh <= {tdi_s, ir_sh[IR_W-1:1]};
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			jt.tdo    <= 1'b0;
			jt.tdo_oe <= 1'b0;
		end else if (tck_fall) begin
			jt.tdo    <= (tap == st_sh_ir) ? ir_sh[0] : dr[0];
			jt.tdo_oe <= (tap == st_sh_ir) | (tap == st_sh_dr);
		end
	end

	assign upd_any  = tck_fall & (tap == st_upd_dr);
	assign upd_dr   = upd_any & ~busy;
	assign upd_ir   = tck_fall & (tap == st_upd_ir);
	assign word_upd = upd_dr & (ir == IR_WORD);
	assign blk_upd  = upd_dr & (ir == IR_BLOCK);
	// entering block reads fetches the next location for the first scan
	assign pref     = upd_ir & (ir_sh == IR_BLOCK) & ~sb_we & ~busy;
	assign go       = (word_upd & (addr_phase ? dr[0] : sb_we))
		| blk_upd | pref;
	assign go_we    = word_upd ? ~addr_phase : sb_we;
	assign inc      = BA_W'(1) << sb_size;

	always_ff @(posedge aclk) begin
		if (!aresetn)
			ir <= IR_BYPASS;
		else if (tck_rise && tap == st_reset)
			ir <= IR_BYPASS;
		else if (upd_ir)
			ir <= ir_sh;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			addr_phase <= 1'b1;
		else if (upd_ir)
			addr_phase <= 1'b1;
		else if (word_upd)
			addr_phase <= ~addr_phase;
	end

	// sb_we keeps the direction of the last access for block repeats
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sb_addr <= '0;
			sb_size <= SIZE_WORD;
			sb_we   <= 1'b0;
		end else if (word_upd && addr_phase) begin
			sb_addr <= {dr[34:1], 2'h0};
			sb_size <= SIZE_WORD;
			sb_we   <= ~dr[0];
		end else if (blk_upd || pref) begin
			sb_addr <= sb_addr + inc;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sb_req   <= 1'b0;
			sb_wdata <= 32'h0;
		end else if (sb_req) begin
			if (sb_ack)
				sb_req <= 1'b0;
		end else if (go) begin
			sb_req <= 1'b1;
			if (go_we)
				sb_wdata <= dr[31:0];
		end
	end

	// cancel may take long; busy stays up until the bus answers
	always_ff @(posedge aclk) begin
		if (!aresetn)
			sb_cancel <= 1'b0;
		else if (!sb_req || sb_ack)
			sb_cancel <= 1'b0;
		else if (upd_ir && ir_sh == IR_CANCEL)
			sb_cancel <= 1'b1;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			err   <= 1'b0;
			rdata <= 32'h0;
		end else if (sb_req && sb_ack) begin
			err <= sb_err | sb_cancel;
			if (!sb_we)
				rdata <= sb_rdata;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			sync_cnt <= 16'h0;
		else if (upd_dr && ir == IR_SYNC)
			sync_cnt <= dr[15:0];
		else if (sync_cnt != 16'h0)
			sync_cnt <= sync_cnt - 16'h1;
	end

	// domain resets are not gated by busy: they must always get through
	always_ff @(posedge aclk) begin
		if (!aresetn)
			dom_rst <= 5'h0;
		else if (upd_any && ir == IR_DRST)
			dom_rst <= dr[4:0];
	end

	assign rst_cpu    = dom_rst[DRST_CPU];
	assign rst_sysbus = dom_rst[DRST_SYS];
	assign rst_debug  = dom_rst[DRST_DBG];
endmodule : jba_dev

/* rtl/jba_host.sv */
// master end: scan sequencer driven through axi4-lite registers
`timescale 1ns/10ps
module jba_host
	import jba_pkg::*;
#(
	parameter int HALF = TCK_HALF
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	jba_if.host              jt,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [7:0]  s_axi_araddr,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp
);
	logic [7:0]      wa;
	logic [31:0]     wd;
	logic [3:0]      ws;
	logic            wr_en;
	logic            start;
	logic [31:0]     cmd;
	logic [DR_W-1:0] tdi_reg;
	logic [DR_W-1:0] tdo_reg;
	logic [1:0]      tdo_q;
	logic            run;
	logic [15:0]     div;
	logic [8:0]      step;
	logic [8:0]      rel;
	logic [8:0]      total;
	logic            in_sh;
	logic            tms_v;
	logic            tdi_v;
	logic [7:0]      pre_tms;
	logic [7:0]      pre_n;
	logic [5:0]      len;
	logic [1:0]      post_tms;
	logic [1:0]      post_n;

	assign wr_en = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
	// partial strobes are answered but leave the registers untouched
	assign start = wr_en & (wa == REG_CMD) & (ws == 4'hf) & ~run;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
			wa            <= 8'h0;
			wd            <= 32'h0;
			ws            <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awready <= 1'b0;
				wa            <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wready <= 1'b0;
				wd           <= s_axi_wdata;
				ws           <= s_axi_wstrb;
			end
			if (wr_en) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (wa == REG_CMD || wa == REG_TDI_LO
					|| wa == REG_TDI_HI) ? RESP_OKAY : RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmd     <= 32'h0;
			tdi_reg <= '0;
		end else if (wr_en && ws == 4'hf && !run) begin
			if (wa == REG_CMD)
				cmd <= wd;
			if (wa == REG_TDI_LO)
				tdi_reg[31:0] <= wd;
			if (wa == REG_TDI_HI)
				tdi_reg[34:32] <= wd[2:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= RESP_OKAY;
			unique case (s_axi_araddr)
			REG_CMD:    s_axi_rdata <= cmd;
			REG_TDI_LO: s_axi_rdata <= tdi_reg[31:0];
			REG_TDI_HI: s_axi_rdata <= {29'h0, tdi_reg[34:32]};
			REG_STATUS: s_axi_rdata <= {31'h0, run};
			REG_TDO_LO: s_axi_rdata <= tdo_reg[31:0];
			REG_TDO_HI: s_axi_rdata <= {29'h0, tdo_reg[34:32]};
			default: begin
				s_axi_rdata <= 32'h0;
				s_axi_rresp <= RESP_SLVERR;
			end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// IR and DR ops are a tms prefix, a data shift and a tms suffix; idle and reset are a tms prefix only
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pre_tms  <= 8'h0;
			pre_n    <= 8'h0;
			len      <= 6'h0;
			post_tms <= 2'h0;
			post_n   <= 2'h0;
		end else if (start) begin
			len      <= wd[1] ? 6'h0 : wd[13:8];
			post_tms <= POST_UPD;
			post_n   <= wd[1] ? 2'h0 : (wd[2] ? 2'h1 : 2'h2);
			unique case (wd[1:0])
			OP_IR:    {pre_tms, pre_n} <= {PRE_IR, 8'h04};
			OP_DR:    {pre_tms, pre_n} <= {PRE_DR, 8'h03};
			OP_IDLE:  {pre_tms, pre_n} <= {8'h0, wd[23:16]};
			OP_RESET: {pre_tms, pre_n} <= {PRE_RESET, 8'h06};
			endcase
		end
	end

	assign rel   = step - 9'(pre_n);
	assign total = 9'(pre_n) + 9'(len) + 9'(post_n);
	assign in_sh = (step >= 9'(pre_n)) && (rel < 9'(len));
	assign tdi_v = in_sh & tdi_reg[rel[5:0]];

	always_comb begin
		if (step < 9'(pre_n))
			tms_v = (step < 9'h8) ? pre_tms[step[2:0]] : 1'b0;
		else if (in_sh)
			tms_v = (rel == 9'(len) - 9'h1);
		else
			tms_v = post_tms[rel[0] ^ len[0]];
	end

	// tck is made here by dividing aclk; tdo is sampled at the rise
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			run    <= 1'b0;
			div    <= 16'h0;
			step   <= 9'h0;
			jt.tck <= 1'b0;
		end else if (start) begin
			run  <= 1'b1;
			div  <= 16'h0;
			step <= 9'h0;
		end else if (run) begin
			if (div == 16'(HALF - 1)) begin
				div    <= 16'h0;
				jt.tck <= ~jt.tck;
				if (!jt.tck)
					step <= step + 9'h1;
				else if (step == total)
					run <= 1'b0;
			end else begin
				div <= div + 16'h1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			jt.tms <= 1'b1;
			jt.tdi <= 1'b0;
		end else if (run && !jt.tck) begin
			jt.tms <= tms_v;
			jt.tdi <= tdi_v;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tdo_q   <= 2'h0;
			tdo_reg <= '0;
		end else begin
			tdo_q <= {tdo_q[0], jt.tdo};
			if (run && !jt.tck && div == 16'(HALF - 1) && in_sh)
				tdo_reg[rel[5:0]] <= tdo_q[1];
		end
	end
endmodule : jba_host

/* verif/jba_assertions.sv */
// concurrent checks on the scan pins and the service bus
`timescale 1ns/10ps
module jba_assertions
	import jba_pkg::*;
(
	input wire logic            aclk,
	input wire logic            aresetn,
	input wire logic            tck,
	input wire logic            tms,
	input wire logic            tdi,
	input wire logic            tdo,
	input wire logic            tdo_oe,
	input wire logic            sb_req,
	input wire logic            sb_we,
	input wire logic [BA_W-1:0] sb_addr,
	input wire logic [1:0]      sb_size,
	input wire logic [31:0]     sb_wdata,
	input wire logic            sb_cancel,
	input wire logic            sb_ack,
	input wire logic            rst_cpu,
	input wire logic            rst_sysbus,
	input wire logic            rst_debug
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	AST_ALIGN: assert property (sb_req |-> sb_addr[1:0] == 2'h0)
		else $error("service bus address not word aligned");
	AST_SIZE: assert property (sb_req |-> sb_size == SIZE_WORD)
		else $error("service bus access not word sized");
	AST_HOLD: assert property (sb_req && !sb_ack |=> sb_req
		&& $stable(sb_addr) && $stable(sb_we) && $stable(sb_wdata))
		else $error("service bus request dropped or changed");
	AST_DROP: assert property (sb_req && sb_ack |=> !sb_req)
		else $error("service bus request not ended after ack");
	AST_CANCEL: assert property (sb_cancel |-> sb_req)
		else $error("abort raised with no access pending");
	AST_REQ_EDGE: assert property ($rose(sb_req) |-> !tck)
		else $error("access started outside an update");
	AST_DRST_EDGE: assert property (
		$changed({rst_cpu, rst_sysbus, rst_debug}) |-> !tck)
		else $error("domain reset moved outside an update");
	// the host may only move its levels while the scan clock is low
	AST_TMS_STEADY: assert property (tck && $past(tck) |->
		$stable(tms) && $stable(tdi))
		else $error("tms or tdi moved while tck high");
	AST_TCK_HIGH: assert property ($rose(tck) |-> tck[*8] ##1 !tck)
		else $error("tck high phase not eight cycles");
	AST_TCK_LOW: assert property ($fell(tck) |-> (!tck)[*8])
		else $error("tck low phase too short");
	AST_TDO_EDGE: assert property ($changed(tdo) |-> !tck)
		else $error("tdo moved while tck high");
	AST_OE_EDGE: assert property ($changed(tdo_oe) |-> !tck)
		else $error("tdo enable moved while tck high");
	COV_WRITE: cover property (sb_req && sb_ack && sb_we);
	COV_READ: cover property (sb_req && sb_ack && !sb_we);
	COV_CANCEL: cover property (sb_cancel && sb_ack);
	COV_DRST: cover property ($rose(rst_cpu));
endmodule : jba_assertions

/* verif/tb_jtag_bus_access_commands.sv */
// self-checking bench: host and device joined over the scan link
`timescale 1ns/10ps
module tb_jtag_bus_access_commands;
	import jba_pkg::*;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid;
	logic        sb_req, sb_we, sb_cancel, sb_ack, sb_err, slow, fail;
	logic        rst_cpu, rst_sysbus, rst_debug;
	logic [7:0]  awaddr, araddr;
	logic [1:0]  bresp, rresp, sb_size, r;
	logic [35:0] sb_addr;
	logic [31:0] wdata, rdata, sb_wdata, sb_rdata, seed, t0, cyc, tck_n;
	logic [31:0] d, w;
	logic [33:0] a;
	logic [4:0]  v, pv;
	logic [15:0] dly;
	logic [34:0] obs;
	logic [68:0] sbe;
	logic [34:0] exp_v[$];
	logic [34:0] exp_m[$];
	logic [68:0] exp_sb[$];
	int          err_count, samples_checked;
	event        scan_done;
	jba_if u_jba_if();
	jba_host u_jba_host (.aclk(aclk), .aresetn(aresetn), .jt(u_jba_if),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_araddr(araddr),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp));
	jba_dev u_jba_dev (.aclk(aclk), .aresetn(aresetn), .jt(u_jba_if),
		.sb_req(sb_req), .sb_we(sb_we), .sb_addr(sb_addr),
		.sb_size(sb_size), .sb_wdata(sb_wdata), .sb_cancel(sb_cancel),
		.sb_ack(sb_ack), .sb_err(sb_err), .sb_rdata(sb_rdata),
		.rst_cpu(rst_cpu), .rst_sysbus(rst_sysbus), .rst_debug(rst_debug));
	jba_assertions u_jba_assertions (.aclk(aclk), .aresetn(aresetn),
		.tck(u_jba_if.tck), .tms(u_jba_if.tms), .tdi(u_jba_if.tdi),
		.tdo(u_jba_if.tdo), .tdo_oe(u_jba_if.tdo_oe), .sb_req(sb_req),
		.sb_we(sb_we), .sb_addr(sb_addr), .sb_size(sb_size),
		.sb_wdata(sb_wdata), .sb_cancel(sb_cancel), .sb_ack(sb_ack),
		.rst_cpu(rst_cpu), .rst_sysbus(rst_sysbus), .rst_debug(rst_debug));
	always #2.5 aclk = ~aclk;
	always @(posedge aclk) cyc <= cyc + 32'h1;
	always @(posedge u_jba_if.tck) tck_n <= tck_n + 32'h1;
	function automatic logic [31:0] mem(input logic [33:0] x);
		return {x[29:0], 2'h0} ^ 32'h5a5a0ff0;
	endfunction : mem
	task automatic cmp(input logic [63:0] got, input logic [63:0] ex);
		samples_checked++;
		if (got !== ex) begin
			err_count++;
			$display("Error t=%0t got=%h exp=%h", $time, got, ex);
		end
	endtask : cmp
	// slow mode models a stuck location: only an abort ends the access
	always @(posedge aclk) begin
		sb_ack <= 1'b0;
		if (!sb_req || sb_ack)
			dly <= slow ? 16'hffff : 16'($random(seed) & 7);
		else if (dly == 16'h0 || sb_cancel) begin
			sb_ack <= 1'b1;
			sb_err <= sb_cancel | fail;
			sb_rdata <= sb_addr[31:0] ^ 32'h5a5a0ff0;
			sbe = exp_sb.pop_front();
			cmp({sb_we, sb_addr}, sbe[68:32]);
			if (sb_we)
				cmp(sb_wdata, sbe[31:0]);
		end else
			dly <= dly - 16'h1;
	end
	always @(scan_done) cmp(obs & exp_m.pop_front(), exp_v.pop_front());
	task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
		awvalid <= 1'b1;
		awaddr <= ad;
		wvalid <= 1'b1;
		wdata <= dt;
		@(posedge aclk);
		while (awvalid || wvalid) begin
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
			@(posedge aclk);
		end
		bready <= 1'b1;
		do @(posedge aclk); while (bvalid !== 1'b1);
		cmp(bresp, RESP_OKAY);
		bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] ad, output logic [31:0] dt,
		output logic [1:0] rs);
		arvalid <= 1'b1;
		araddr <= ad;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		rready <= 1'b1;
		do @(posedge aclk); while (rvalid !== 1'b1);
		dt = rdata;
		rs = rresp;
		rready <= 1'b0;
	endtask : rd
	task automatic scan(input logic [1:0] op, input logic [5:0] len,
		input logic ch, input logic [34:0] din, input logic [34:0] ev,
		input logic [34:0] em);
		logic [31:0] lo;
		logic [31:0] hi;
		logic [1:0]  rs;
		exp_v.push_back(ev);
		exp_m.push_back(em);
		wr(REG_TDI_LO, din[31:0]);
		wr(REG_TDI_HI, {29'h0, din[34:32]});
		wr(REG_CMD, {8'h00, 8'h0a, 2'h0, len, 5'h00, ch, op});
		lo = 32'h1;
		while (lo[0] !== 1'b0)
			rd(REG_STATUS, lo, rs);
		rd(REG_TDO_LO, lo, rs);
		rd(REG_TDO_HI, hi, rs);
		cmp(rs, RESP_OKAY);
		obs = {hi[2:0], lo};
		->scan_done;
	endtask : scan
	task automatic ir(input logic [4:0] code, input logic [4:0] cap);
		scan(OP_IR, 6'h05, 1'b0, {30'h0, code}, {30'h0, cap}, 35'h1f);
	endtask : ir
	task automatic summarize;
		$display("checked %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : summarize
	initial begin
		repeat (40000) @(posedge aclk);
		err_count++;
		summarize();
	end
	initial begin
		{aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = 7'h0;
		{awaddr, araddr, wdata, sb_ack, sb_err, sb_rdata, slow, fail} = 'h0;
		{cyc, tck_n} = 64'h0;
		seed = 32'ha960c148;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		scan(OP_RESET, 6'h00, 1'b0, 35'h0, 35'h0, 35'h0);
		rd(8'h20, d, r);
		cmp({r, d}, {RESP_SLVERR, 32'h0});
		a = 34'($random(seed));
		w = $random(seed);
		ir(IR_WORD, 5'h01);
		exp_sb.push_back({1'b1, a, 2'h0, w});
		scan(OP_DR, LEN_WORD, 1'b0, {a, 1'b0}, 35'h0, 35'h0);
		scan(OP_DR, LEN_WORD, 1'b0, {3'h0, w}, 35'h0, 35'h0);
		ir(IR_WORD, 5'h01);
		exp_sb.push_back({1'b0, a, 2'h0, 32'h0});
		scan(OP_DR, LEN_WORD, 1'b0, {a, 1'b1}, 35'h0, 35'h0);
		scan(OP_DR, LEN_WORD, 1'b0, 35'h0, {3'h0, mem(a)}, 35'h3ffffffff);
		$display("word access test done");
		for (int k = 1; k <= 4; k++)
			exp_sb.push_back({1'b0, a + 34'(k), 2'h0, 32'h0});
		ir(IR_BLOCK, 5'h01);
		for (int k = 1; k <= 3; k++) begin
			t0 = tck_n;
			scan(OP_DR, 6'h20, k < 3, 35'h0, {3'h0, mem(a + 34'(k))},
				35'hffffffff);
			if (k < 3)
				cmp(tck_n - t0, 32'd36);
		end
		$display("block access test done");
		slow <= 1'b1;
		a = 34'($random(seed));
		exp_sb.push_back({1'b0, a, 2'h0, 32'h0});
		ir(IR_WORD, 5'h01);
		scan(OP_DR, LEN_WORD, 1'b0, {a, 1'b1}, 35'h0, 35'h0);
		scan(OP_DR, LEN_WORD, 1'b0, 35'h0, 35'h100000000, 35'h100000000);
		ir(IR_CANCEL, 5'h05);
		scan(OP_DR, LEN_ONE, 1'b0, 35'h1, 35'h0, 35'h1);
		slow <= 1'b0;
		ir(IR_WORD, 5'h09);
		fail <= 1'b1;
		exp_sb.push_back({1'b0, a, 2'h0, 32'h0});
		scan(OP_DR, LEN_WORD, 1'b0, {a, 1'b1}, 35'h0, 35'h0);
		fail <= 1'b0;
		ir(IR_WORD, 5'h09);
		exp_sb.push_back({1'b0, a, 2'h0, 32'h0});
		scan(OP_DR, LEN_WORD, 1'b0, {a, 1'b1}, 35'h0, 35'h0);
		ir(IR_WORD, 5'h01);
		$display("cancel test done");
		ir(IR_SYNC, 5'h01);
		scan(OP_DR, LEN_SYNC, 1'b1, 35'h800, 35'h0, 35'h0);
		t0 = cyc;
		scan(OP_DR, 6'h02, 1'b1, 35'h0, 35'h1, 35'h3);
		do scan(OP_DR, 6'h02, 1'b1, 35'h0, 35'h0, 35'h0);
		while (obs[0] === 1'b1 && cyc - t0 < 32'd4000);
		cmp(cyc - t0 > 32'd2000 && cyc - t0 < 32'd2400, 1'b1);
		$display("sync test done");
		pv = 5'h0;
		for (int k = 0; k < 3; k++) begin
			v = (k == 0) ? 5'h1f : (k == 1) ? 5'($random(seed)) : 5'h00;
			ir(IR_DRST, CAP_PLAIN);
			scan(OP_DR, LEN_DRST, 1'b0, {30'h0, v}, {30'h0, pv},
				35'h1f);
			scan(OP_IDLE, 6'h00, 1'b0, 35'h0, 35'h0, 35'h0);
			cmp({rst_debug, rst_sysbus, rst_cpu}, {v[4], v[3], v[0]});
			pv = v;
		end
		$display("domain reset test done");
		cmp(exp_sb.size(), 0);
		summarize();
	end
endmodule : tb_jtag_bus_access_commands
